/* File: logic/mfs_pkg.sv */
// Package for the motor field and speed supervisor: constants and carrier types.
package mfs_pkg;

    localparam int unsigned THR_W  = 16;
    localparam int unsigned MEAS_W = 16;
    localparam int unsigned DLY_W  = 16;

    // Threshold settings: 100 counts per percent of the nominal quantity.
    localparam logic [THR_W-1:0] PCT_SCALE       = 16'h0064;
    localparam logic [THR_W-1:0] FLD_OVR_DISABLE = 16'h34BC; // 135 percent.
    localparam logic [THR_W-1:0] SPEED_OFF       = 16'h0000;
    localparam int unsigned      PCT_DIV         = 10000;

    // Fault word bit positions.
    localparam int unsigned FW1_FLD_OVR_BIT = 14;
    localparam int unsigned FW2_OVRSPD_BIT  = 15;
    localparam int unsigned FW3_FLD_LOW_BIT = 8;
    localparam int unsigned FW4_SPD_FB_BIT  = 4;

    // Delay in supervision ticks; default chosen to be one tick per unit.
    localparam logic [DLY_W-1:0] DLY_DEFAULT = 16'h0001;

    typedef enum logic [2:0] {
        MFS_MODE_NORMAL  = 3'b000,
        MFS_MODE_FIXOPT  = 3'b001,
        MFS_MODE_EMFOPT  = 3'b010,
        MFS_MODE_FIXROPT = 3'b011,
        MFS_MODE_EMFROPT = 3'b100,
        MFS_MODE_OTHER   = 3'b101
    } mfs_mode_t;

    typedef enum logic [1:0] {
        MFS_SEL_FAULT = 2'b00,
        MFS_SEL_ALARM = 2'b01,
        MFS_SEL_NONE  = 2'b10,
        MFS_SEL_RSVD  = 2'b11
    } mfs_fbsel_t;

    typedef enum logic [1:0] {
        MFS_SRC_ENC  = 2'b00,
        MFS_SRC_TACH = 2'b01,
        MFS_SRC_ENC2 = 2'b10,
        MFS_SRC_RSVD = 2'b11
    } mfs_src_t;

    typedef struct packed {
        logic [THR_W-1:0] min_field_trip_level;
        logic [DLY_W-1:0] min_field_trip_delay;
        logic [THR_W-1:0] field_overcurrent_level;
        logic [THR_W-1:0] speed_monitor_level;
        logic [THR_W-1:0] emf_monitor_level;
        logic [THR_W-1:0] overspeed_limit;
        mfs_fbsel_t       speed_feedback_fault_selector;
        mfs_src_t         speed_source;
        mfs_mode_t        field_control_mode;
    } mfs_cfg_t;

    typedef struct packed {
        logic [MEAS_W-1:0] field_current;
        logic [MEAS_W-1:0] nominal_field_current;
        logic [MEAS_W-1:0] field_heating_reference;
        logic [MEAS_W-1:0] field_current_reference;
        logic [MEAS_W-1:0] emf;
        logic [MEAS_W-1:0] encoder_speed;
        logic [MEAS_W-1:0] tacho_speed;
        logic [MEAS_W-1:0] second_encoder_speed;
        logic [MEAS_W-1:0] motor_speed;
    } mfs_meas_t;

    typedef struct packed {
        logic field_overcurrent_fault;
        logic overspeed_fault;
        logic field_undercurrent_fault;
        logic speed_feedback_fault;
    } mfs_flt_t;

endpackage

/* File: logic/mfs_supervisor.sv */
// Motor field, speed-feedback and overspeed protection supervisor.
`timescale 1ns/1ps
module mfs_supervisor #(
    parameter int unsigned MEAS_W = mfs_pkg::MEAS_W
) (
    // Clock and reset.
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // Supervision control.
    input  wire logic              i_tick,
    input  wire logic              i_fault_reset,
    input  wire logic              i_field_heat_econ,
    // Settings and measurements.
    input  wire mfs_pkg::mfs_cfg_t  i_cfg,
    input  wire mfs_pkg::mfs_meas_t i_meas,
    // Fault words and alarm.
    output logic [15:0]            o_fault_word_one,
    output logic [15:0]            o_fault_word_two,
    output logic [15:0]            o_fault_word_three,
    output logic [15:0]            o_fault_word_four,
    output logic                   o_speed_feedback_alarm
);

    mfs_pkg::mfs_flt_t           flt_r;
    mfs_pkg::mfs_flt_t           flt_nxt;
    logic                        alarm_r;
    logic [mfs_pkg::DLY_W-1:0]   low_cnt_r;
    logic [mfs_pkg::DLY_W-1:0]   low_cnt_nxt;

    // Percent thresholds scaled to measurement units; 32-bit products avoid overflow.
    wire [31:0] nom_w   = {16'h0000, i_meas.nominal_field_current};
    wire [31:0] min_abs = (32'(i_cfg.min_field_trip_level) * nom_w) / 32'(mfs_pkg::PCT_DIV);
    wire [31:0] ovr_abs = (32'(i_cfg.field_overcurrent_level) * nom_w) / 32'(mfs_pkg::PCT_DIV);
    wire        opti_mode = (i_cfg.field_control_mode == mfs_pkg::MFS_MODE_FIXOPT)
                          | (i_cfg.field_control_mode == mfs_pkg::MFS_MODE_EMFOPT)
                          | (i_cfg.field_control_mode == mfs_pkg::MFS_MODE_FIXROPT)
                          | (i_cfg.field_control_mode == mfs_pkg::MFS_MODE_EMFROPT);
    wire [31:0] heat_half = {17'h0_0000, i_meas.field_heating_reference[15:1]};
    wire [31:0] ref_half  = {17'h0_0000, i_meas.field_current_reference[15:1]};
    // Heating and economy take precedence over the optimised modes.
    wire [31:0] low_level = i_field_heat_econ ? heat_half : (opti_mode ? ref_half : min_abs);
    wire        fld_low   = {16'h0000, i_meas.field_current} < low_level;
    wire        dly_done  = low_cnt_r >= i_cfg.min_field_trip_delay;
    wire        ovr_on    = i_cfg.field_overcurrent_level != mfs_pkg::FLD_OVR_DISABLE;
    wire        fld_ovr   = ovr_on & ({16'h0000, i_meas.field_current} > ovr_abs);
    wire [15:0] spd_sel   = (i_cfg.speed_source == mfs_pkg::MFS_SRC_TACH) ? i_meas.tacho_speed :
                            (i_cfg.speed_source == mfs_pkg::MFS_SRC_ENC2) ?
                            i_meas.second_encoder_speed : i_meas.encoder_speed;
    wire        fb_armed  = i_meas.emf > i_cfg.emf_monitor_level;
    wire        fb_bad    = fb_armed & (spd_sel <= i_cfg.speed_monitor_level);
    wire        fb_trip   = fb_bad & (i_cfg.speed_feedback_fault_selector == mfs_pkg::MFS_SEL_FAULT);
    wire        fb_alarm  = fb_bad & (i_cfg.speed_feedback_fault_selector == mfs_pkg::MFS_SEL_ALARM);
    wire        spd_on    = i_cfg.overspeed_limit != mfs_pkg::SPEED_OFF;
    wire        ovrspd    = spd_on & (i_meas.motor_speed > i_cfg.overspeed_limit);

    // A new trip in the reset cycle wins over the reset so no event is lost.
    always_comb begin
        flt_nxt     = i_fault_reset ? '0 : flt_r;
        low_cnt_nxt = low_cnt_r;
        if (i_tick) begin
            low_cnt_nxt = !fld_low ? '0 : (dly_done ? low_cnt_r : low_cnt_r + 1'b1);
            if (fld_low && dly_done) begin
                flt_nxt.field_undercurrent_fault = 1'b1;
            end
            if (fld_ovr) begin
                flt_nxt.field_overcurrent_fault = 1'b1;
            end
            if (fb_trip) begin
                flt_nxt.speed_feedback_fault = 1'b1;
            end
            if (ovrspd) begin
                flt_nxt.overspeed_fault = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_r     <= '0;
            low_cnt_r <= '0;
            alarm_r   <= 1'b0;
        end else begin
            flt_r     <= flt_nxt;
            low_cnt_r <= low_cnt_nxt;
            alarm_r   <= i_tick ? fb_alarm : alarm_r;
        end
    end

    always_comb begin
        o_fault_word_one   = '0;
        o_fault_word_two   = '0;
        o_fault_word_three = '0;
        o_fault_word_four  = '0;
        o_fault_word_one[mfs_pkg::FW1_FLD_OVR_BIT]   = flt_r.field_overcurrent_fault;
        o_fault_word_two[mfs_pkg::FW2_OVRSPD_BIT]    = flt_r.overspeed_fault;
        o_fault_word_three[mfs_pkg::FW3_FLD_LOW_BIT] = flt_r.field_undercurrent_fault;
        o_fault_word_four[mfs_pkg::FW4_SPD_FB_BIT]   = flt_r.speed_feedback_fault;
    end
    assign o_speed_feedback_alarm = alarm_r;

    a_ovr_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick && fld_ovr |=> o_fault_word_one[mfs_pkg::FW1_FLD_OVR_BIT])
        else $error("Field overcurrent not latched.");
    a_ovr_disable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick && !ovr_on |-> !fld_ovr)
        else $error("Overcurrent check active at disable level.");
    a_spd_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick && spd_on && (i_meas.motor_speed > i_cfg.overspeed_limit)
        |=> o_fault_word_two[mfs_pkg::FW2_OVRSPD_BIT])
        else $error("Overspeed not latched.");
    a_spd_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_cfg.overspeed_limit == mfs_pkg::SPEED_OFF) && !$past(flt_r.overspeed_fault)
        && !flt_r.overspeed_fault |=> !o_fault_word_two[mfs_pkg::FW2_OVRSPD_BIT])
        else $error("Overspeed set with limit zero.");
    a_fb_arm: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !fb_armed |-> !fb_trip && !fb_alarm)
        else $error("Feedback check fired while disarmed.");
    a_fb_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick && fb_armed && (spd_sel <= i_cfg.speed_monitor_level) &&
        (i_cfg.speed_feedback_fault_selector == mfs_pkg::MFS_SEL_FAULT)
        |=> o_fault_word_four[mfs_pkg::FW4_SPD_FB_BIT])
        else $error("Speed feedback fault not latched.");
    a_low_wait: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(flt_r.field_undercurrent_fault) |-> $past(fld_low) && $past(dly_done))
        else $error("Undercurrent fault before delay.");
    a_heat_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_field_heat_econ |-> low_level == heat_half)
        else $error("Heating level not used.");
    a_opti_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_field_heat_econ && opti_mode |-> low_level == ref_half)
        else $error("Optimised mode level not used.");
    a_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_fault_word_three[mfs_pkg::FW3_FLD_LOW_BIT] && !i_fault_reset
        |=> o_fault_word_three[mfs_pkg::FW3_FLD_LOW_BIT])
        else $error("Undercurrent fault dropped without reset.");

    // The checks below pin down latching, the reset path and which cause may raise a bit.
    // A fault that rises without a qualifying tick points at a stale next-state term.
    // Spare bits of the fault words must stay clear so software can mask whole words.
    a_ovr_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_fault_word_one[mfs_pkg::FW1_FLD_OVR_BIT] && !i_fault_reset
        |=> o_fault_word_one[mfs_pkg::FW1_FLD_OVR_BIT])
        else $error("Overcurrent fault dropped without reset.");

    a_spd_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_fault_word_two[mfs_pkg::FW2_OVRSPD_BIT] && !i_fault_reset
        |=> o_fault_word_two[mfs_pkg::FW2_OVRSPD_BIT])
        else $error("Overspeed fault dropped without reset.");

    a_fb_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_fault_word_four[mfs_pkg::FW4_SPD_FB_BIT] && !i_fault_reset
        |=> o_fault_word_four[mfs_pkg::FW4_SPD_FB_BIT])
        else $error("Feedback fault dropped without reset.");

    a_reset_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_fault_reset && !i_tick
        |=> (o_fault_word_one == 16'h0000) && (o_fault_word_two == 16'h0000)
            && (o_fault_word_three == 16'h0000) && (o_fault_word_four == 16'h0000))
        else $error("Fault reset did not clear the fault words.");

    a_quiet_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_tick && !i_fault_reset |=> flt_r == $past(flt_r))
        else $error("Fault state changed without a tick.");

    a_min_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_field_heat_econ && !opti_mode |-> low_level == min_abs)
        else $error("Programmed minimum level not used.");

    a_low_count: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick && !fld_low |=> low_cnt_r == '0)
        else $error("Undercurrent delay count not restarted.");

    a_alarm_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_tick |=> o_speed_feedback_alarm == $past(fb_alarm))
        else $error("Feedback alarm does not follow the tick.");

    a_fb_none: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_cfg.speed_feedback_fault_selector == mfs_pkg::MFS_SEL_NONE
        |-> !fb_trip && !fb_alarm)
        else $error("Feedback reaction with selector none.");

    a_ovr_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(flt_r.field_overcurrent_fault) |-> $past(i_tick) && $past(fld_ovr))
        else $error("Overcurrent fault without cause.");

    a_spd_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(flt_r.overspeed_fault) |-> $past(i_tick) && $past(ovrspd))
        else $error("Overspeed fault without cause.");

    a_fb_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(flt_r.speed_feedback_fault) |-> $past(i_tick) && $past(fb_trip))
        else $error("Feedback fault without cause.");

    a_word_layout: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ((o_fault_word_one & ~(16'h0001 << mfs_pkg::FW1_FLD_OVR_BIT)) == 16'h0000)
        && ((o_fault_word_two & ~(16'h0001 << mfs_pkg::FW2_OVRSPD_BIT)) == 16'h0000)
        && ((o_fault_word_three & ~(16'h0001 << mfs_pkg::FW3_FLD_LOW_BIT)) == 16'h0000)
        && ((o_fault_word_four & ~(16'h0001 << mfs_pkg::FW4_SPD_FB_BIT)) == 16'h0000))
        else $error("Spare fault word bit set.");

    c_low:  cover property (@(posedge i_mclk) $rose(flt_r.field_undercurrent_fault));
    c_ovr:  cover property (@(posedge i_mclk) $rose(flt_r.field_overcurrent_fault));
    c_fb:   cover property (@(posedge i_mclk) $rose(flt_r.speed_feedback_fault));
    c_spd:  cover property (@(posedge i_mclk) $rose(flt_r.overspeed_fault));
    c_alm:  cover property (@(posedge i_mclk) $rose(o_speed_feedback_alarm));

endmodule // mfs_supervisor

/* File: verification/mfs_drive_model.sv */
// Behavioural model of the drive control side that issues supervision ticks.
`timescale 1ns/1ps
module mfs_drive_model #(
    parameter int unsigned TICK_DIV = 4
) (
    // Clock and reset.
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // Supervision tick.
    output logic      o_tick
);
    int unsigned cnt;
    // The tick moves on the falling edge so the supervisor always samples it settled.
    always @(negedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= 0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
            o_tick <= (cnt == TICK_DIV - 1);
        end
    end
endmodule // mfs_drive_model

/* File: verification/tb.sv */
// Self-checking testbench for the motor field and speed supervisor.
`timescale 1ns/1ps
module tb;
    logic               i_mclk;
    logic               i_rst_n;
    logic               i_tick;
    logic               i_fault_reset;
    logic               i_field_heat_econ;
    mfs_pkg::mfs_cfg_t  cfg;
    mfs_pkg::mfs_meas_t meas;
    logic [15:0]        fw1, fw2, fw3, fw4;
    logic               alarm;
    int                 fails;
    int                 total_checks;

    mfs_supervisor DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tick(i_tick),
        .i_fault_reset(i_fault_reset), .i_field_heat_econ(i_field_heat_econ), .i_cfg(cfg),
        .i_meas(meas), .o_fault_word_one(fw1), .o_fault_word_two(fw2),
        .o_fault_word_three(fw3), .o_fault_word_four(fw4), .o_speed_feedback_alarm(alarm));
    mfs_drive_model model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_tick(i_tick));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge i_mclk iff i_tick);
        @(negedge i_mclk);
    endtask

    task automatic chk(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Nominal field 1000, so 50 percent is 500 and 125 percent is 1250 in measurement units.
    task automatic base();
        meas = '0;
        meas.nominal_field_current = 16'h03E8;
        meas.field_current = 16'h0384;
        meas.field_heating_reference = 16'h0320;
        meas.field_current_reference = 16'h0578;
        cfg.min_field_trip_level = 16'h1388;
        cfg.min_field_trip_delay = 16'h0000;
        cfg.field_overcurrent_level = 16'h30D4;
        cfg.speed_monitor_level = 16'h000F;
        cfg.emf_monitor_level = 16'h0032;
        cfg.overspeed_limit = 16'h0708;
        cfg.speed_feedback_fault_selector = mfs_pkg::MFS_SEL_FAULT;
        cfg.speed_source = mfs_pkg::MFS_SRC_ENC;
        cfg.field_control_mode = mfs_pkg::MFS_MODE_NORMAL;
        i_field_heat_econ = 1'b0;
        i_fault_reset = 1'b1;
        ticks(1);
        i_fault_reset = 1'b0;
    endtask

    task automatic t_over();
        base();
        meas.field_current = 16'h04E2;
        ticks(2);
        chk(fw1[14], 1'b0, "overcurrent at level");
        meas.field_current = 16'h04E3;
        ticks(1);
        chk(fw1[14], 1'b1, "overcurrent above level");
        chk16(fw1, 16'h4000, "fault word one layout");
        meas.field_current = 16'h0384;
        ticks(2);
        chk(fw1[14], 1'b1, "overcurrent latch");
        base();
        chk(fw1[14], 1'b0, "overcurrent reset");
        cfg.field_overcurrent_level = mfs_pkg::FLD_OVR_DISABLE;
        meas.field_current = 16'hFFFF;
        ticks(2);
        chk(fw1[14], 1'b0, "overcurrent disabled");
        cfg.field_overcurrent_level = 16'h30D4;
        i_fault_reset = 1'b1;
        ticks(1);
        i_fault_reset = 1'b0;
        chk(fw1[14], 1'b1, "trip wins over reset");
    endtask

    task automatic t_speed();
        base();
        meas.motor_speed = 16'h0708;
        ticks(2);
        chk(fw2[15], 1'b0, "overspeed at limit");
        meas.motor_speed = 16'h0709;
        ticks(1);
        chk(fw2[15], 1'b1, "overspeed above limit");
        chk16(fw2, 16'h8000, "fault word two layout");
        base();
        cfg.overspeed_limit = mfs_pkg::SPEED_OFF;
        meas.motor_speed = 16'hFFFF;
        ticks(2);
        chk(fw2[15], 1'b0, "overspeed disabled");
    endtask

    task automatic t_low();
        logic [2:0] m;
        base();
        cfg.min_field_trip_delay = 16'h0002;
        meas.field_current = 16'h01F3;
        ticks(2);
        chk(fw3[8], 1'b0, "undercurrent before delay");
        ticks(1);
        chk(fw3[8], 1'b1, "undercurrent after delay");
        chk16(fw3, 16'h0100, "fault word three layout");
        base();
        i_field_heat_econ = 1'b1;
        meas.field_current = 16'h01C2;
        ticks(2);
        chk(fw3[8], 1'b0, "heating level not reached");
        meas.field_current = 16'h018F;
        ticks(1);
        chk(fw3[8], 1'b1, "heating level undershot");
        for (m = 3'b001; m <= 3'b100; m++) begin
            base();
            cfg.field_control_mode = mfs_pkg::mfs_mode_t'(m);
            meas.field_current = 16'h0258;
            ticks(1);
            chk(fw3[8], 1'b1, "optimised mode level");
        end
    endtask

    task automatic t_fb();
        base();
        meas.emf = 16'h0033;
        meas.encoder_speed = 16'h000F;
        ticks(1);
        chk(fw4[4], 1'b1, "feedback fault");
        base();
        meas.emf = 16'h0032;
        meas.encoder_speed = 16'h000F;
        ticks(2);
        chk(fw4[4], 1'b0, "check not armed");
        base();
        cfg.speed_feedback_fault_selector = mfs_pkg::MFS_SEL_ALARM;
        meas.emf = 16'h0033;
        ticks(1);
        chk(alarm, 1'b1, "feedback alarm");
        chk(fw4[4], 1'b0, "alarm without fault");
        base();
        cfg.speed_source = mfs_pkg::MFS_SRC_TACH;
        meas.emf = 16'h0033;
        meas.tacho_speed = 16'h0010;
        ticks(1);
        chk(fw4[4], 1'b0, "tacho speed plausible");
        cfg.speed_source = mfs_pkg::MFS_SRC_ENC2;
        meas.second_encoder_speed = 16'h000F;
        ticks(1);
        chk(fw4[4], 1'b1, "second encoder implausible");
        chk16(fw4, 16'h0010, "fault word four layout");
        base();
        cfg.speed_feedback_fault_selector = mfs_pkg::MFS_SEL_NONE;
        meas.emf = 16'h0033;
        ticks(2);
        chk(fw4[4], 1'b0, "selector none no fault");
        chk(alarm, 1'b0, "selector none no alarm");
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        fails = 0;
        total_checks = 0;
        i_rst_n = 1'b0;
        i_fault_reset = 1'b0;
        i_field_heat_econ = 1'b0;
        cfg = '0;
        meas = '0;
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        t_over();
        t_speed();
        t_low();
        t_fb();
        final_report();
    end

    // The tests need a few hundred cycles; twenty thousand means a hang.
    initial begin
        #1000000;
        fails++;
        final_report();
    end
endmodule // tb
